// ### rtl/sync_preamble_chanspace_cfg.sv
// Modem configuration registers with sync, preamble and spacing logic.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.svh"
module sync_preamble_chanspace_cfg (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire cfg_pkg::cfg_req_t cfg_req,
  output logic      [7:0]        cfg_rdata,
  output logic                   cfg_rvalid,
  input  wire logic [31:0]       sync_word,
  input  wire logic [23:0]       base_word,
  input  wire logic [7:0]        channel_index,
  input  wire cfg_pkg::rx_bit_t  rx,
  input  wire logic              carrier_sense,
  input  wire logic              rx_restart,
  output logic                   rx_qualified,
  output logic                   sync_hit,
  output logic      [4:0]        preamble_bytes,
  output logic      [26:0]       carrier_word
);
  import cfg_pkg::*;

  // ===========================================================
  // Register state
  logic [2:0] sync_mode_reg;
  logic [2:0] preamble_code_reg;
  logic       pre_spare_reg;
  logic [1:0] spacing_exponent_reg;
  logic [7:0] spacing_mantissa_reg;
  logic [7:0] rdata_next;
  logic       wr_sync;
  logic       wr_pre;
  logic       wr_mant;

  always_comb begin
    wr_sync = cfg_req.wr && (cfg_req.addr == `SYNC_CFG_OFS);
    wr_pre  = cfg_req.wr && (cfg_req.addr == `PRE_SPC_OFS);
    wr_mant = cfg_req.wr && (cfg_req.addr == `MANT_OFS);
  end

  // ===========================================================
  // Sync-word qualifier mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_mode_reg <= `SYNC_MODE_RST;
    end else if (ce && wr_sync) begin
      sync_mode_reg <= cfg_req.wdata[`SYNC_MODE_HI:`SYNC_MODE_LO];
    end
  end

  // ===========================================================
  // Preamble length and spacing exponent
  // Bits 3:2 have no storage, so writes to them simply vanish.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preamble_code_reg    <= `PRE_CODE_RST;
      pre_spare_reg        <= `PRE_SPARE_RST;
      spacing_exponent_reg <= `SPC_EXP_RST;
    end else if (ce && wr_pre) begin
      preamble_code_reg    <=
        cfg_req.wdata[`PRE_CODE_HI:`PRE_CODE_LO];
      pre_spare_reg        <= cfg_req.wdata[`PRE_SPARE_BIT];
      spacing_exponent_reg <=
        cfg_req.wdata[`SPC_EXP_HI:`SPC_EXP_LO];
    end
  end

  // ===========================================================
  // Spacing mantissa
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      spacing_mantissa_reg <= `SPC_MANT_RST;
    end else if (ce && wr_mant) begin
      spacing_mantissa_reg <= cfg_req.wdata;
    end
  end

  // ===========================================================
  // Read-back
  always_comb begin
    case (cfg_req.addr)
      `SYNC_CFG_OFS: rdata_next = {5'h00, sync_mode_reg};
      `PRE_SPC_OFS:  rdata_next = {pre_spare_reg, preamble_code_reg,
                                   2'b00, spacing_exponent_reg};
      `MANT_OFS:     rdata_next = spacing_mantissa_reg;
      default:       rdata_next = 8'h00;
    endcase
  end

  // Read data is held until the next read so the serial shifter
  // may take it at any later point of its byte.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata  <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rvalid <= cfg_req.rd;
      if (cfg_req.rd) begin
        cfg_rdata <= rdata_next;
      end
    end
  end

  // ===========================================================
  // Preamble byte count for the transmitter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preamble_bytes <= 5'h04;
    end else if (ce) begin
      preamble_bytes <= preamble_len(preamble_code_reg);
    end
  end

  // ===========================================================
  // Sync qualifier and carrier word
  sync_qualifier u_sync (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .ce            (ce),
    .mode          (sync_mode_reg),
    .sync_word     (sync_word),
    .rx            (rx),
    .carrier_sense (carrier_sense),
    .restart       (rx_restart),
    .qualified     (rx_qualified),
    .sync_hit      (sync_hit)
  );

  channel_offset u_channel_index (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .ce               (ce),
    .base_word        (base_word),
    .spacing_mantissa (spacing_mantissa_reg),
    .spacing_exponent (spacing_exponent_reg),
    .channel_index    (channel_index),
    .carrier_word     (carrier_word)
  );

  // ===========================================================
  // Checks
  logic after_reset_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      after_reset_reg <= 1'b1;
    end else begin
      after_reset_reg <= 1'b0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // The first edge after reset still samples every reset value; bit 7 (pre_spare_reg) is the one not checked here.
  reset_values_a: assert property (after_reset_reg |->
      sync_mode_reg == 3'h2 && preamble_code_reg == 3'h2 &&
      spacing_exponent_reg == 2'h2 &&
      spacing_mantissa_reg == 8'hf8)
    else $error("register reset values wrong");

  reset_outputs_a: assert property (after_reset_reg |->
      preamble_bytes == 5'h04 && cfg_rdata == 8'h00 && !cfg_rvalid)
    else $error("outputs not at reset values");

  // ===========================================================
  // Write checks
  exp_write_a: assert property (ce && wr_pre |=>
      spacing_exponent_reg == $past(cfg_req.wdata[1:0]))
    else $error("spacing exponent write lost");

  code_write_a: assert property (ce && wr_pre |=>
      preamble_code_reg == $past(cfg_req.wdata[6:4]))
    else $error("preamble code write lost");

  // Bit 7 is kept only so that a host reads back what it wrote.
  spare_write_a: assert property (ce && wr_pre |=>
      pre_spare_reg == $past(cfg_req.wdata[7]))
    else $error("bit 7 write lost");

  mant_write_a: assert property (ce && wr_mant |=>
      spacing_mantissa_reg == $past(cfg_req.wdata))
    else $error("spacing mantissa write lost");

  mant_hold_a: assert property (!(ce && wr_mant) |=>
      $stable(spacing_mantissa_reg))
    else $error("spacing mantissa changed without a write");

  pre_hold_a: assert property (!(ce && wr_pre) |=>
      $stable(preamble_code_reg) && $stable(spacing_exponent_reg) &&
      $stable(pre_spare_reg))
    else $error("preamble register changed without a write");

  mode_write_a: assert property (ce && wr_sync |=>
      sync_mode_reg == $past(cfg_req.wdata[2:0]))
    else $error("sync mode write lost");

  mode_hold_a: assert property (!(ce && wr_sync) |=>
      $stable(sync_mode_reg))
    else $error("sync mode changed without a write");

  // ===========================================================
  // Read-back checks
  // Read data is held against the register as it stood at the taken
  // edge, so a write in the same cycle must not leak into it.
  read_pulse_a: assert property (ce |=> cfg_rvalid == $past(cfg_req.rd))
    else $error("read strobe and valid pulse disagree");

  rdata_hold_a: assert property (ce && !cfg_req.rd |=>
      $stable(cfg_rdata))
    else $error("read data moved without a read");

  unused_zero_a: assert property (ce && cfg_req.rd &&
      cfg_req.addr == 6'h13 |=> cfg_rvalid && cfg_rdata[3:2] == 2'b00)
    else $error("unused bits 3:2 read non-zero");

  read_mode_a: assert property (ce && cfg_req.rd &&
      cfg_req.addr == `SYNC_CFG_OFS |=>
      cfg_rdata == {5'h00, $past(sync_mode_reg)})
    else $error("sync mode read-back wrong");

  read_fields_a: assert property (ce && cfg_req.rd &&
      cfg_req.addr == `PRE_SPC_OFS |=>
      cfg_rdata[6:4] == $past(preamble_code_reg) &&
      cfg_rdata[1:0] == $past(spacing_exponent_reg))
    else $error("preamble register read-back wrong");

  read_mant_a: assert property (ce && cfg_req.rd &&
      cfg_req.addr == `MANT_OFS |=>
      cfg_rdata == $past(spacing_mantissa_reg))
    else $error("mantissa read-back wrong");

  read_unmapped_a: assert property (ce && cfg_req.rd &&
      cfg_req.addr != `SYNC_CFG_OFS && cfg_req.addr != `PRE_SPC_OFS &&
      cfg_req.addr != `MANT_OFS |=> cfg_rdata == 8'h00)
    else $error("unmapped address read non-zero");

  // ===========================================================
  // Preamble map checks
  preamble_min_a: assert property (ce && preamble_code_reg == 3'h0
      |=> preamble_bytes == 5'h02)
    else $error("code 0 does not give 2 preamble bytes");

  preamble_c1_a: assert property (ce && preamble_code_reg == 3'h1
      |=> preamble_bytes == 5'h03)
    else $error("code 1 does not give 3 preamble bytes");

  preamble_c2_a: assert property (ce && preamble_code_reg == 3'h2
      |=> preamble_bytes == 5'h04)
    else $error("code 2 does not give 4 preamble bytes");

  preamble_c3_a: assert property (ce && preamble_code_reg == 3'h3
      |=> preamble_bytes == 5'h06)
    else $error("code 3 does not give 6 preamble bytes");

  preamble_c4_a: assert property (ce && preamble_code_reg == 3'h4
      |=> preamble_bytes == 5'h08)
    else $error("code 4 does not give 8 preamble bytes");

  preamble_c5_a: assert property (ce && preamble_code_reg == 3'h5
      |=> preamble_bytes == 5'h0c)
    else $error("code 5 does not give 12 preamble bytes");

  preamble_c6_a: assert property (ce && preamble_code_reg == 3'h6
      |=> preamble_bytes == 5'h10)
    else $error("code 6 does not give 16 preamble bytes");

  preamble_map_a: assert property (ce && preamble_code_reg == 3'h7
      ##1 ce && $stable(preamble_code_reg) |=>
      preamble_bytes == 5'h18)
    else $error("code 7 does not give 24 preamble bytes");

  // ===========================================================
  // Freeze and pulse checks
  freeze_a: assert property (!ce |=> $stable(cfg_rdata) &&
      $stable(cfg_rvalid) && $stable(preamble_bytes))
    else $error("state moved while clock enable low");

  freeze_regs_a: assert property (!ce |=> $stable(sync_mode_reg) &&
      $stable(preamble_code_reg) && $stable(spacing_exponent_reg) &&
      $stable(spacing_mantissa_reg))
    else $error("register moved while clock enable low");

  freeze_out_a: assert property (!ce |=> $stable(carrier_word) &&
      $stable(rx_qualified) && $stable(sync_hit))
    else $error("output moved while clock enable low");

  // A hit is a single-cycle pulse that always comes with the level.
  hit_pulse_a: assert property (ce && sync_hit |=> !sync_hit)
    else $error("sync hit lasted more than one cycle");

  hit_qual_a: assert property (sync_hit |-> rx_qualified)
    else $error("sync hit without qualified reception");

  cover_mant_c: cover property (ce && wr_mant ##1 ce ##1 ce);
  cover_read_c: cover property (ce && cfg_req.rd &&
      cfg_req.addr == 6'h13 ##1 cfg_rvalid);
  cover_hit_c: cover property (sync_mode_reg == 3'h3 && sync_hit);
  cover_cs_c: cover property (sync_mode_reg == 3'h4 && rx_qualified);
endmodule
`default_nettype wire

// ### rtl/cfg_defines.svh
// Register offsets, field positions, reset values and error tolerances.
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

`define SYNC_CFG_OFS      6'h12
`define PRE_SPC_OFS       6'h13
`define MANT_OFS          6'h14

`define SYNC_MODE_RST     3'h2
`define PRE_CODE_RST      3'h2
`define PRE_SPARE_RST     1'h0
`define SPC_EXP_RST       2'h2
`define SPC_MANT_RST      8'hf8

`define PRE_SPARE_BIT     7
`define PRE_CODE_HI       6
`define PRE_CODE_LO       4
`define SPC_EXP_HI        1
`define SPC_EXP_LO        0
`define SYNC_MODE_HI      2
`define SYNC_MODE_LO      0

`define SPC_HIDDEN_ONE    12'h100
`define ERR_TOL_16        6'h01
`define ERR_TOL_32        6'h02

`endif

// ### rtl/cfg_pkg.sv
// Shared types for the modem configuration block.
package cfg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic data;
  } rx_bit_t;

  typedef enum logic {QUAL_SEARCH, QUAL_FOUND} qual_state_t;

  // Preamble code to minimum byte count.
  function automatic logic [4:0] preamble_len(input logic [2:0] code);
    case (code)
      3'h0:    preamble_len = 5'h02;
      3'h1:    preamble_len = 5'h03;
      3'h2:    preamble_len = 5'h04;
      3'h3:    preamble_len = 5'h06;
      3'h4:    preamble_len = 5'h08;
      3'h5:    preamble_len = 5'h0c;
      3'h6:    preamble_len = 5'h10;
      default: preamble_len = 5'h18;
    endcase
  endfunction

endpackage

// ### rtl/sync_qualifier.sv
// Sync-word qualifier: sync search with error tolerance and carrier gate.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.svh"
module sync_qualifier (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [2:0]       mode,
  input  wire logic [31:0]      sync_word,
  input  wire cfg_pkg::rx_bit_t rx,
  input  wire logic             carrier_sense,
  input  wire logic             restart,
  output logic                  qualified,
  output logic                  sync_hit
);
  import cfg_pkg::*;

  qual_state_t state_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [5:0]  err16;
  logic [5:0]  err32;
  logic        match;
  logic        hit;

  function automatic logic [5:0] ones(input logic [31:0] v);
    ones = 6'h00;
    for (int i = 0; i < 32; i++) begin
      ones = ones + {5'h00, v[i]};
    end
  endfunction

  always_comb begin
    shift_next = {shift_reg[30:0], rx.data};
    err16 = ones({16'h0000, shift_next[15:0] ^ sync_word[15:0]});
    err32 = ones(shift_next ^ sync_word);
    case (mode[1:0])
      2'h1:    match = (err16 <= `ERR_TOL_16);
      2'h2:    match = (err16 == 6'h00);
      2'h3:    match = (err32 <= `ERR_TOL_32);
      default: match = 1'b0;
    endcase
    // Modes 0 and 4 qualify without any bit search.
    hit = (mode[1:0] == 2'h0) ? 1'b1 : (rx.valid && match);
    hit = hit && (!mode[2] || carrier_sense);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= 32'h0000_0000;
    end else if (ce && rx.valid) begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= QUAL_SEARCH;
      qualified <= 1'b0;
      sync_hit  <= 1'b0;
    end else if (ce) begin
      sync_hit <= 1'b0;
      case (state_reg)
        QUAL_SEARCH: begin
          if (hit) begin
            state_reg <= QUAL_FOUND;
            qualified <= 1'b1;
            sync_hit  <= 1'b1;
          end
        end
        QUAL_FOUND: begin
          if (restart) begin
            state_reg <= QUAL_SEARCH;
            qualified <= 1'b0;
          end
        end
        default: begin
          state_reg <= QUAL_SEARCH;
          qualified <= 1'b0;
        end
      endcase
    end
  end

  // ===========================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  free_pass_a: assert property (ce && state_reg == QUAL_SEARCH &&
      mode == 3'h0 |=> qualified && sync_hit)
    else $error("mode 0 did not qualify at once");
  exact_miss_a: assert property (ce && state_reg == QUAL_SEARCH &&
      mode == 3'h2 && err16 != 6'h00 |=> !sync_hit)
    else $error("inexact 16-bit word accepted");
  tol16_pass_a: assert property (ce && state_reg == QUAL_SEARCH &&
      rx.valid && mode == 3'h1 && err16 == 6'h01 |=> sync_hit)
    else $error("one-bit error 16-bit word rejected");
  tol32_reject_a: assert property (ce && state_reg == QUAL_SEARCH &&
      mode[1:0] == 2'h3 && err32 > 6'h02 |=> !sync_hit)
    else $error("32-bit word with three errors accepted");
  cs_gate_a: assert property (ce && state_reg == QUAL_SEARCH &&
      mode[2] && !carrier_sense |=> !sync_hit)
    else $error("hit without carrier sense");
  cs_only_a: assert property (ce && state_reg == QUAL_SEARCH &&
      mode == 3'h4 && carrier_sense |=> sync_hit)
    else $error("mode 4 ignored carrier sense");
  cover_mode7_c: cover property (ce && mode == 3'h7 ##1 sync_hit);
endmodule
`default_nettype wire

// ### rtl/channel_offset.sv
// Carrier word from base word, channel index and channel spacing.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.svh"
module channel_offset (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [23:0] base_word,
  input  wire logic [7:0]  spacing_mantissa,
  input  wire logic [1:0]  spacing_exponent,
  input  wire logic [7:0]  channel_index,
  output logic      [26:0] carrier_word
);
  // Result is in steps of f_xosc / 2^18; the base word is in steps
  // of f_xosc / 2^16, so it is shifted by two to share that unit.
  logic [11:0] spacing;
  logic [19:0] offset;
  logic [26:0] carrier_next;

  always_comb begin
    spacing = (`SPC_HIDDEN_ONE + {4'h0, spacing_mantissa})
              << spacing_exponent;
    offset = spacing * {12'h000, channel_index};
    carrier_next = {1'b0, base_word, 2'b00} + {7'h00, offset};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      carrier_word <= 27'h000_0000;
    end else if (ce) begin
      carrier_word <= carrier_next;
    end
  end

  // ===========================================================
  // Checks
  carrier_math_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce |=> int'(carrier_word) == int'($past(base_word)) * 4 +
        (256 + int'($past(spacing_mantissa))) *
        (1 << $past(spacing_exponent)) * int'($past(channel_index)))
    else $error("carrier word does not match spacing formula");
endmodule
`default_nettype wire

// ### verification/cfg_host.sv
// Host-side model that issues register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  input  wire logic              ref_clk,
  output var  cfg_pkg::cfg_req_t req,
  input  wire logic [7:0]        rdata,
  input  wire logic              rvalid
);
  import cfg_pkg::*;

  // ==========================================================
  // Access tasks
  initial req = '0;

  // Each strobe lasts one cycle; every task starts on a fresh edge.
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    req.wr = 1'b0;
    // Released data is inverted so that stale bytes never look valid.
    req.wdata = ~d;
  endtask

  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    int k;
    @(posedge ref_clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #1;
    req.rd = 1'b0;
    k = 0;
    while (rvalid !== 1'b1 && k < 4) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ### verification/test_sync_preamble_chanspace_cfg.sv
// Testbench for the modem configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.svh"
`define check(nm, ex, gt) \
  begin \
    compares++; \
    if ((gt) !== (ex)) begin \
      $display("BAD %s exp %0h got %0h", nm, ex, gt); \
      err_count++; \
    end \
  end
module test_sync_preamble_chanspace_cfg;
  import cfg_pkg::*;

  // ==========================================================
  // Signals and instances
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  cfg_req_t    cfg_req;
  logic [7:0]  cfg_rdata;
  logic        cfg_rvalid;
  logic [31:0] sync_word = 32'h9c4e_2b71;
  logic [23:0] base_word = 24'h12_3456;
  logic [7:0]  channel_index = 8'h05;
  rx_bit_t     rx = '0;
  logic        carrier_sense = 1'b0;
  logic        rx_restart = 1'b0;
  logic        rx_qualified;
  logic        sync_hit;
  logic [4:0]  preamble_bytes;
  logic [26:0] carrier_word;
  logic [7:0]  rd;
  int          err_count = 0;
  int          compares = 0;
  int          hits = 0;
  logic [4:0]  pre_tab [8] = '{5'h02, 5'h03, 5'h04, 5'h06,
                               5'h08, 5'h0c, 5'h10, 5'h18};

  cfg_host host (.ref_clk(ref_clk), .req(cfg_req), .rdata(cfg_rdata),
                 .rvalid(cfg_rvalid));

  sync_preamble_chanspace_cfg uut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .sync_word(sync_word), .base_word(base_word),
    .channel_index(channel_index), .rx(rx),
    .carrier_sense(carrier_sense), .rx_restart(rx_restart),
    .rx_qualified(rx_qualified), .sync_hit(sync_hit),
    .preamble_bytes(preamble_bytes), .carrier_word(carrier_word));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (sync_hit === 1'b1) hits++;
  end

  // ==========================================================
  // Helpers
  function automatic logic [26:0] exp_carrier(input logic [7:0] m,
                                              input logic [1:0] e);
    exp_carrier = {1'b0, base_word, 2'b00} +
                  ((27'(channel_index) * (27'h000_0100 + 27'(m))) << e);
  endfunction

  task automatic give_verdict();
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Restart is held while the mode changes, since a found state
  // ignores mode writes. A hit count of -1 skips that comparison.
  task automatic qual_case(input logic [2:0] m, input logic [31:0] w,
                           input int n, input logic cs, input logic q,
                           input int h);
    int i;
    int hits0;
    rx_restart = 1'b1;
    carrier_sense = cs;
    host.write_reg(`SYNC_CFG_OFS, {5'h00, m});
    repeat (2) @(posedge ref_clk);
    #1;
    rx_restart = 1'b0;
    hits0 = hits;
    for (i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      #1;
      rx = '{valid: 1'b1, data: w[i]};
    end
    @(posedge ref_clk);
    #1;
    rx.valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `check("rx_qualified", q, rx_qualified)
    if (h >= 0) `check("sync_hit count", h, hits - hits0)
  endtask

  // ==========================================================
  // Tests
  initial begin
    #2_000_000;
    err_count++;
    give_verdict();
  end

  initial begin
    int i;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    `check("preamble_bytes", 5'h04, preamble_bytes)
    `check("carrier_word", exp_carrier(8'hf8, 2'h2), carrier_word)
    host.read_reg(`SYNC_CFG_OFS, rd);
    `check("sync cfg", 8'h02, rd)
    host.read_reg(`PRE_SPC_OFS, rd);
    `check("preamble cfg", 8'h22, rd)
    host.read_reg(`MANT_OFS, rd);
    `check("mantissa", 8'hf8, rd)
    host.read_reg(6'h15, rd);
    `check("unmapped", 8'h00, rd)
    host.write_reg(`PRE_SPC_OFS, 8'hff);
    host.read_reg(`PRE_SPC_OFS, rd);
    `check("preamble cfg", 8'hf3, rd)
    for (i = 0; i < 8; i++) begin
      host.write_reg(`PRE_SPC_OFS, {1'b0, i[2:0], 4'h2});
      repeat (2) @(posedge ref_clk);
      #1;
      `check("preamble_bytes", pre_tab[i], preamble_bytes)
    end
    host.write_reg(`MANT_OFS, 8'ha5);
    host.read_reg(`MANT_OFS, rd);
    `check("mantissa", 8'ha5, rd)
    ce = 1'b0;
    host.write_reg(`MANT_OFS, 8'h00);
    ce = 1'b1;
    host.read_reg(`MANT_OFS, rd);
    `check("mantissa frozen", 8'ha5, rd)
    host.write_reg(`MANT_OFS, 8'h00);
    host.write_reg(`PRE_SPC_OFS, 8'h20);
    repeat (2) @(posedge ref_clk);
    #1;
    `check("carrier_word", exp_carrier(8'h00, 2'h0), carrier_word)
    host.write_reg(`MANT_OFS, 8'hff);
    host.write_reg(`PRE_SPC_OFS, 8'h23);
    channel_index = 8'hff;
    repeat (2) @(posedge ref_clk);
    #1;
    `check("carrier_word", exp_carrier(8'hff, 2'h3), carrier_word)
    host.write_reg(`PRE_SPC_OFS, 8'h21);
    repeat (2) @(posedge ref_clk);
    #1;
    `check("carrier_word", exp_carrier(8'hff, 2'h1), carrier_word)
    qual_case(3'h2, sync_word, 16, 1'b0, 1'b1, 1);
    qual_case(3'h2, sync_word ^ 32'h0000_0100, 16, 1'b0, 1'b0, 0);
    qual_case(3'h1, sync_word ^ 32'h0000_0100, 16, 1'b0, 1'b1, 1);
    qual_case(3'h1, sync_word ^ 32'h0000_0101, 16, 1'b0, 1'b0, 0);
    qual_case(3'h3, sync_word ^ 32'h0001_0100, 32, 1'b0, 1'b1, 1);
    qual_case(3'h3, sync_word ^ 32'h0101_0100, 32, 1'b0, 1'b0, 0);
    qual_case(3'h0, sync_word, 0, 1'b0, 1'b1, -1);
    qual_case(3'h4, sync_word, 0, 1'b0, 1'b0, 0);
    qual_case(3'h4, sync_word, 0, 1'b1, 1'b1, -1);
    qual_case(3'h6, sync_word, 16, 1'b0, 1'b0, 0);
    qual_case(3'h6, sync_word, 16, 1'b1, 1'b1, 1);
    qual_case(3'h5, sync_word ^ 32'h0000_0100, 16, 1'b1, 1'b1, 1);
    qual_case(3'h7, sync_word ^ 32'h0001_0100, 32, 1'b1, 1'b1, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
